// ===== design/dal_top.sv
`timescale 1ns/100ps
`include "dal_cfg.svh"
// Behaviour
// [RQ1] Each channel independently acts as high or low alarm.
// [RQ2] Enable off suppresses the channel; stored parameters stay untouched.
// [RQ3] Polarity picks idle output level; alarm drives the opposite level.
// [RQ4] Condition arises when display reaches setpoint in the chosen direction.
// [RQ5] High alarm clears only below setpoint minus hysteresis.
// [RQ6] Low alarm clears only above setpoint plus hysteresis.
// [RQ7] Delay 0 to 3600 s in seconds; zero switches at once.
// [RQ8] Lamp flashes during delay, output switches after full delay, then steady.
// [RQ9] Condition lost during delay discards the count.
// [RQ10] Display alternation starts only once the output is in alarm.
// [RQ11] Silence 0 to 3600 s; nonzero turns the advance button into accept.
// [RQ12] Accept forces non-alarm for silence time, then re-alarms if present.
// [RQ13] Lamp flashes during silence until expiry or condition clears.
// [RQ14] Alternation suppressed while silenced; only with output in alarm.
// [RQ15] Alternate value and references; both alarmed shows both in turn.
// [RQ16] One front lamp per channel shows its alarm status.
// [RQ17] Setpoint accepted only inside the 3.8 to 20.2 mA display span.
// [RQ18] Digit entry: up/down change digit, advance moves, exit returns.
// [RQ19] Direct access off keeps setpoints unreachable from display mode.
// [RQ20] Direct access guarded by own four digit code, entered per digit.
// [RQ21] All-zero code skips checking; reset state is access off, code zero.
// [RQ22] Wrong code or twenty idle seconds returns to display mode.
module dal_top #(
  parameter int unsigned TICK_CYCLES = `DAL_SECOND_NS / `DAL_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Measurement and limits
  input wire logic signed [15:0] disp_value,
  input wire logic signed [15:0] sp_min,
  input wire logic signed [15:0] sp_max,
  // Configuration
  input wire dal_pkg::dal_chan_cfg_s chan_cfg [2],
  input wire logic display_flash_option,
  input wire logic direct_setpoint_access,
  input wire logic [15:0] access_code,
  input wire logic [1:0] cfg_sp_we,
  input wire logic signed [15:0] cfg_sp_value,
  // Push buttons, raw pins
  input wire dal_pkg::dal_buttons_s btn_pin,
  // Alarm outputs and lamps
  output logic [1:0] alarm_out,
  output logic [1:0] lamp,
  output dal_pkg::dal_disp_e disp_sel,
  // Setpoint access view
  output dal_pkg::dal_access_e access_state,
  output logic [1:0] access_digit,
  output logic access_chan,
  output logic signed [15:0] edit_value,
  output logic [15:0] code_entry,
  output logic signed [15:0] first_setpoint,
  output logic signed [15:0] second_setpoint
);
  import dal_pkg::*;

  // ---------------------------------
  // Second tick and blink
  // ---------------------------------
  logic [31:0] tick_cnt;
  logic tick;
  logic blink;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (tick_cnt == TICK_CYCLES - 1)
    begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      blink <= 1'b0;
    else if (tick)
      blink <= ~blink;

  // ---------------------------------
  // Button synchronisers and edges
  // ---------------------------------
  dal_buttons_s btn_s1, btn_s2, btn_q, press;
  logic combo, accept;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      btn_s1 <= '0;
      btn_s2 <= '0;
      btn_q <= '0;
    end
    else
    begin
      btn_s1 <= btn_pin;
      btn_s2 <= btn_s1;
      btn_q <= btn_s2;
    end

  assign press = btn_s2 & ~btn_q;
  assign combo = (press.next_digit & btn_s2.up) | (press.up & btn_s2.next_digit);
  assign accept = press.next_digit & ~btn_s2.up & (access_state == ST_DISPLAY);

  // ---------------------------------
  // Alarm channels
  // ---------------------------------
  logic signed [15:0] sp [2];
  logic [1:0] cond, alarm, silenced, active;
  logic [11:0] dcnt [2];
  logic [11:0] scnt [2];

  assign first_setpoint = sp[0];
  assign second_setpoint = sp[1];

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic signed [17:0] val_x, lo_th, hi_th;
    assign val_x = {{2{disp_value[15]}}, disp_value};
    assign lo_th = {{2{sp[c][15]}}, sp[c]} - {2'b00, chan_cfg[c].hysteresis_value};
    assign hi_th = {{2{sp[c][15]}}, sp[c]} + {2'b00, chan_cfg[c].hysteresis_value};

    always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
        cond[c] <= 1'b0;
      else if (!chan_cfg[c].enable) // RQ2
        cond[c] <= 1'b0;
      else if (chan_cfg[c].high_low_select) // RQ1
        cond[c] <= cond[c] ? !(val_x < lo_th) : (disp_value >= sp[c]); // RQ4 RQ5
      else
        cond[c] <= cond[c] ? !(val_x > hi_th) : (disp_value <= sp[c]); // RQ4 RQ6

    always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
        dcnt[c] <= 12'h000;
        alarm[c] <= 1'b0;
      end
      else if (!cond[c])
      begin
        dcnt[c] <= 12'h000; // RQ9
        alarm[c] <= 1'b0;
      end
      else if (!alarm[c])
      begin
        if (dcnt[c] >= chan_cfg[c].alarm_delay_time) // RQ7 RQ8
          alarm[c] <= 1'b1;
        else if (tick)
          dcnt[c] <= dcnt[c] + 12'h001;
      end

    always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
        silenced[c] <= 1'b0;
        scnt[c] <= 12'h000;
      end
      else if (!alarm[c])
        silenced[c] <= 1'b0; // RQ13
      else if (!silenced[c])
      begin
        if (accept && chan_cfg[c].silence_time != 12'h000) // RQ11 RQ12
        begin
          silenced[c] <= 1'b1;
          scnt[c] <= 12'h000;
        end
      end
      else if (scnt[c] >= chan_cfg[c].silence_time)
        silenced[c] <= 1'b0; // RQ12
      else if (tick)
        scnt[c] <= scnt[c] + 12'h001;

    assign active[c] = alarm[c] & ~silenced[c];

    always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
        alarm_out[c] <= 1'b0;
        lamp[c] <= 1'b0;
      end
      else
      begin
        alarm_out[c] <= active[c] ^ chan_cfg[c].idle_closed; // RQ3
        lamp[c] <= active[c] | (cond[c] & blink); // RQ8 RQ13 RQ16
      end
  end

  // ---------------------------------
  // Display alternation
  // ---------------------------------
  logic ref_turn;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      disp_sel <= DSEL_VALUE;
      ref_turn <= 1'b0;
    end
    else if (!display_flash_option || active == 2'b00) // RQ10 RQ14
      disp_sel <= DSEL_VALUE;
    else if (tick)
    begin
      if (disp_sel != DSEL_VALUE)
        disp_sel <= DSEL_VALUE;
      else if (active == 2'b11) // RQ15
      begin
        disp_sel <= ref_turn ? DSEL_SECOND_REF : DSEL_FIRST_REF;
        ref_turn <= ~ref_turn;
      end
      else
        disp_sel <= active[0] ? DSEL_FIRST_REF : DSEL_SECOND_REF; // RQ15
    end

  // ---------------------------------
  // Setpoint access from display mode
  // ---------------------------------
  logic [4:0] idle_s;
  logic any_press;
  logic signed [15:0] weight;
  logic [3:0] nib;

  assign any_press = |press;

  always_comb
    case (access_digit)
      2'd0: weight = 16'sh0001;
      2'd1: weight = 16'sh000A;
      2'd2: weight = 16'sh0064;
      default: weight = 16'sh03E8;
    endcase

  assign nib = code_entry[access_digit*4 +: 4];

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      idle_s <= 5'd0;
    else if (access_state == ST_DISPLAY || any_press)
      idle_s <= 5'd0;
    else if (tick)
      idle_s <= idle_s + 5'd1;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      access_state <= ST_DISPLAY;
      access_digit <= 2'd0;
      access_chan <= 1'b0;
      edit_value <= `DAL_SETPOINT_RST;
      code_entry <= `DAL_CODE_DEFAULT;
    end
    else if (access_state != ST_DISPLAY && idle_s == 5'(`DAL_TIMEOUT_S))
      access_state <= ST_DISPLAY; // RQ22
    else
      case (access_state)
        ST_DISPLAY:
          if (combo && direct_setpoint_access) // RQ19
          begin
            access_digit <= 2'd0;
            code_entry <= `DAL_CODE_DEFAULT;
            access_chan <= 1'b0;
            access_state <= (access_code == `DAL_CODE_DEFAULT) ? ST_SELECT : ST_CODE; // RQ21
          end
        ST_CODE:
          if (press.exit_btn)
            access_state <= (code_entry == access_code) ? ST_SELECT : ST_DISPLAY; // RQ20 RQ22
          else if (press.next_digit)
            access_digit <= access_digit + 2'd1;
          else if (press.up) // RQ20
            code_entry[access_digit*4 +: 4] <= (nib >= `DAL_BCD_MAX) ? 4'h0 : nib + 4'h1;
          else if (press.down)
            code_entry[access_digit*4 +: 4] <= (nib == 4'h0) ? `DAL_BCD_MAX : nib - 4'h1;
        ST_SELECT:
          if (press.exit_btn)
            access_state <= ST_DISPLAY;
          else if (press.up || press.down)
            access_chan <= ~access_chan;
          else if (press.next_digit)
          begin
            edit_value <= sp[access_chan];
            access_digit <= 2'd0;
            access_state <= ST_EDIT;
          end
        ST_EDIT:
          if (press.exit_btn)
            access_state <= ST_SELECT; // RQ18
          else if (press.next_digit)
            access_digit <= access_digit + 2'd1; // RQ18
          else if (press.up)
            edit_value <= edit_value + weight; // RQ18
          else if (press.down)
            edit_value <= edit_value - weight;
        default:
          access_state <= ST_DISPLAY;
      endcase

  // Setpoint store, in-range config load or in-range commit
  logic commit;
  assign commit = access_state == ST_EDIT && press.exit_btn
    && edit_value >= sp_min && edit_value <= sp_max; // RQ17

  for (genvar c = 0; c < 2; c++)
  begin : g_sp
    always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
        sp[c] <= `DAL_SETPOINT_RST;
      else if (cfg_sp_we[c] && cfg_sp_value >= sp_min && cfg_sp_value <= sp_max) // RQ17
        sp[c] <= cfg_sp_value;
      else if (commit && access_chan == 1'(c))
        sp[c] <= edit_value;
  end

  // ---------------------------------
  // Assertions
  // ---------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_idle_level;
    $past(rst_n) |-> alarm_out[0] == ($past(active[0]) ^ $past(chan_cfg[0].idle_closed));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("bad output level"); // RQ3

  property p_disabled;
    !chan_cfg[0].enable |=> !cond[0] ##1 !alarm[0];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled channel alarms"); // RQ2

  property p_high_set;
    chan_cfg[0].enable && chan_cfg[0].high_low_select && disp_value >= sp[0] |=> cond[0];
  endproperty
  a_high_set: assert property (p_high_set) else $error("high condition missed"); // RQ4

  property p_low_set;
    chan_cfg[1].enable && !chan_cfg[1].high_low_select && disp_value <= sp[1] |=> cond[1];
  endproperty
  a_low_set: assert property (p_low_set) else $error("low condition missed"); // RQ1

  property p_high_hold;
    cond[0] && chan_cfg[0].enable && chan_cfg[0].high_low_select
      && !(g_chan[0].val_x < g_chan[0].lo_th) |=> cond[0];
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high cleared early"); // RQ5

  property p_low_hold;
    cond[1] && chan_cfg[1].enable && !chan_cfg[1].high_low_select
      && !(g_chan[1].val_x > g_chan[1].hi_th) |=> cond[1];
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low cleared early"); // RQ6

  property p_zero_delay;
    cond[0] && chan_cfg[0].alarm_delay_time == 12'h000 && $stable(cond[0]) |=> alarm[0];
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay late"); // RQ7

  property p_restart;
    !cond[0] |=> dcnt[0] == 12'h000 && !alarm[0];
  endproperty
  a_restart: assert property (p_restart) else $error("delay not discarded"); // RQ9

  property p_silence;
    alarm[1] && !silenced[1] && accept && chan_cfg[1].silence_time != 12'h000
      |=> silenced[1] ##1 alarm_out[1] == chan_cfg[1].idle_closed;
  endproperty
  a_silence: assert property (p_silence) else $error("accept ignored"); // RQ12

  property p_flash_only_active;
    disp_sel != DSEL_VALUE |-> $past(display_flash_option) && $past(active) != 2'b00;
  endproperty
  a_flash_only_active: assert property (p_flash_only_active) else $error("alt w/o alarm"); // RQ14

  property p_access_off;
    access_state == ST_DISPLAY && !direct_setpoint_access |=> access_state == ST_DISPLAY;
  endproperty
  a_access_off: assert property (p_access_off) else $error("access while off"); // RQ19

  property p_wrong_code;
    access_state == ST_CODE && press.exit_btn && code_entry != access_code
      && idle_s != 5'(`DAL_TIMEOUT_S) |=> access_state == ST_DISPLAY;
  endproperty
  a_wrong_code: assert property (p_wrong_code) else $error("wrong code accepted"); // RQ22

  c_alarm: cover property (cond[0] ##[1:40] alarm[0]);
  c_silenced: cover property (silenced[1] ##1 !silenced[1] && alarm[1]);
  c_both_refs: cover property (disp_sel == DSEL_FIRST_REF ##[1:20] disp_sel == DSEL_SECOND_REF);
  c_commit: cover property (commit);

endmodule : dal_top

// ===== design/dal_cfg.svh
`ifndef DAL_CFG_SVH
`define DAL_CFG_SVH
// Timing
`define DAL_CLK_PERIOD_NS 8
`define DAL_SECOND_NS 1000000000
`define DAL_TIMEOUT_S 20
// Limits and widths
`define DAL_MAX_SECONDS 3600
`define DAL_DIGITS 4
// Reset values
`define DAL_SETPOINT_RST 16'sh0000
`define DAL_CODE_DEFAULT 16'h0000
`define DAL_BCD_MAX 4'h9
`endif

// ===== design/dal_pkg.sv
package dal_pkg;

  // ---------------------------------
  // Per channel configuration
  // ---------------------------------
  typedef struct packed {
    logic enable;
    logic high_low_select;
    logic idle_closed;
    logic [15:0] hysteresis_value;
    logic [11:0] alarm_delay_time;
    logic [11:0] silence_time;
  } dal_chan_cfg_s;

  typedef struct packed {
    logic next_digit;
    logic up;
    logic down;
    logic exit_btn;
  } dal_buttons_s;

  typedef enum logic [1:0] {
    ST_DISPLAY = 2'b00,
    ST_CODE = 2'b01,
    ST_SELECT = 2'b10,
    ST_EDIT = 2'b11
  } dal_access_e;

  typedef enum logic [1:0] {
    DSEL_VALUE = 2'b00,
    DSEL_FIRST_REF = 2'b01,
    DSEL_SECOND_REF = 2'b10
  } dal_disp_e;

endpackage : dal_pkg

// ===== dv/dal_btn_model.sv
`timescale 1ns/100ps
module dal_btn_model #(
  parameter int HOLD = 6
) (
  // Clock
  input wire logic clk,
  // Press request
  input wire logic go,
  input wire dal_pkg::dal_buttons_s cmd,
  // Button pins
  output dal_pkg::dal_buttons_s btn_pin
);
  import dal_pkg::*;
  int cnt = 0;
  dal_buttons_s held = '0;

  assign btn_pin = held;

  // ------------------------------
  // Pin held for HOLD cycles, then released low
  // ------------------------------
  always @(posedge clk)
  begin
    if (go)
    begin
      held <= cmd;
      cnt <= HOLD;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
    else
    begin
      held <= '0;
      cnt <= 0;
    end
  end
endmodule : dal_btn_model

// ===== dv/tb_dal_top.sv
`timescale 1ns/100ps
module tb_dal_top;
  import dal_pkg::*;
  localparam int TK = 10;
  logic clk;
  logic rst_n;
  logic signed [15:0] disp_value;
  dal_chan_cfg_s cfg [2];
  logic display_flash_option;
  logic direct_setpoint_access;
  logic [1:0] cfg_sp_we;
  logic signed [15:0] cfg_sp_value;
  dal_buttons_s btn_pin;
  dal_buttons_s cmd;
  logic go;
  logic [1:0] alarm_out;
  logic [1:0] lamp;
  dal_disp_e disp_sel;
  dal_access_e access_state;
  logic signed [15:0] first_setpoint;
  logic signed [15:0] second_setpoint;
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 32'h905c;
  logic [1:0] q[$];
  logic [15:0] acode;
  logic [1:0] seen;
  int alt;
  localparam dal_buttons_s B_NEXT = 4'h8;
  localparam dal_buttons_s B_UP = 4'h4;
  localparam dal_buttons_s B_EXIT = 4'h1;
  localparam dal_buttons_s B_COMBO = 4'hc;

  dal_top #(.TICK_CYCLES(TK)) i_dal_top (
    .clk(clk), .rst_n(rst_n), .disp_value(disp_value),
    .sp_min(16'shff83), .sp_max(16'sh278d), .chan_cfg(cfg),
    .display_flash_option(display_flash_option),
    .direct_setpoint_access(direct_setpoint_access), .access_code(acode),
    .cfg_sp_we(cfg_sp_we), .cfg_sp_value(cfg_sp_value), .btn_pin(btn_pin),
    .alarm_out(alarm_out), .lamp(lamp), .disp_sel(disp_sel),
    .access_state(access_state), .access_digit(), .access_chan(), .edit_value(),
    .code_entry(), .first_setpoint(first_setpoint), .second_setpoint(second_setpoint));

  dal_btn_model i_dal_btn_model (.clk(clk), .go(go), .cmd(cmd), .btn_pin(btn_pin));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------
  // Compare and helper tasks
  // ------------------------------
  task chk_alarm(input logic [1:0] e, input logic [1:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value alarm_out expected %b seen %b", e, g);
    end
  endtask : chk_alarm

  task chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task expect_alarm(input logic [1:0] v, input int lim);
    int i;
    q.push_back(v);
    for (i = 0; i < lim && q.size() > 0; i++)
      step(1);
    if (q.size() > 0)
    begin
      mismatches++;
      $display("wrong value alarm_out expected %b seen %b", v, alarm_out);
      q.delete();
    end
  endtask : expect_alarm

  task press(input dal_buttons_s b);
    cmd = b;
    go = 1'b1;
    step(1);
    go = 1'b0;
  endtask : press

  task tap(input dal_buttons_s b);
    press(b);
    step(12);
  endtask : tap

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // ------------------------------
  // Output watcher
  // ------------------------------
  always @(alarm_out)
  begin
    if (rst_n === 1'b1)
    begin
      if (q.size() == 0)
        chk_alarm(2'bxx, alarm_out);
      else
        chk_alarm(q.pop_front(), alarm_out);
    end
  end

  initial
  begin
    #(8 * 6000);
    mismatches++;
    report_and_stop();
  end

  // ------------------------------
  // Stimulus
  // ------------------------------
  initial
  begin
    rst_n = 1'b0;
    disp_value = 16'sh1388;
    cfg[0] = '{1'b0, 1'b1, 1'b0, 16'h00c8, 12'h000, 12'h000};
    cfg[1] = '{1'b1, 1'b0, 1'b1, 16'h0032, 12'h003, 12'h002};
    display_flash_option = 1'b1;
    direct_setpoint_access = 1'b0;
    acode = 16'h0000;
    cfg_sp_we = 2'b00;
    cfg_sp_value = 16'sh0000;
    cmd = '0;
    go = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    expect_alarm(2'b10, 5);
    cfg_sp_value = 16'sh2328;
    cfg_sp_we = 2'b01;
    step(1);
    cfg_sp_value = 16'sh03e8;
    cfg_sp_we = 2'b10;
    step(1);
    cfg_sp_value = 16'sh4e20;
    cfg_sp_we = 2'b01;
    step(1);
    cfg_sp_we = 2'b00;
    step(1);
    chk_val("first_setpoint", 16'h2328, first_setpoint);
    chk_val("second_setpoint", 16'h03e8, second_setpoint);
    disp_value = 16'sh251c;
    step(20);
    cfg[0].enable = 1'b1;
    expect_alarm(2'b11, 5);
    disp_value = 16'sh1388;
    expect_alarm(2'b10, 5);
    repeat (40)
    begin
      disp_value = 16'(1100 + ($unsigned($random(seed)) % 7800));
      step(1);
    end
    disp_value = 16'sh2328;
    expect_alarm(2'b11, 5);
    disp_value = 16'sh2292;
    step(20);
    disp_value = 16'sh225f;
    expect_alarm(2'b10, 5);
    disp_value = 16'sh03e8;
    step(20);
    chk_val("disp_sel", 16'(DSEL_VALUE), 16'(disp_sel));
    disp_value = 16'sh044c;
    step(3);
    disp_value = 16'sh03e8;
    step(2);
    seen = 2'b00;
    repeat (16)
    begin
      step(1);
      seen = seen | (lamp[1] ? 2'b10 : 2'b01);
    end
    chk_val("lamp", 16'h0003, 16'(seen));
    chk_val("alarm_out", 16'h0002, 16'(alarm_out));
    expect_alarm(2'b00, 40);
    alt = 0;
    repeat (3)
    begin
      step(5);
      chk_val("lamp", 16'h0002, 16'(lamp));
      alt = alt + int'(disp_sel == DSEL_SECOND_REF);
    end
    chk_val("disp_sel", 16'h0001, 16'(alt != 0));
    press(B_NEXT);
    expect_alarm(2'b10, 10);
    seen = 2'b00;
    alt = 0;
    repeat (15)
    begin
      step(1);
      seen = seen | (lamp[1] ? 2'b10 : 2'b01);
      alt = alt + int'(disp_sel != DSEL_VALUE);
    end
    chk_val("lamp", 16'h0003, 16'(seen));
    chk_val("disp_sel", 16'h0000, 16'(alt));
    expect_alarm(2'b00, 40);
    disp_value = 16'sh0410;
    step(20);
    disp_value = 16'sh041b;
    expect_alarm(2'b10, 5);
    disp_value = 16'sh1388;
    press('{1'b1, 1'b1, 1'b0, 1'b0});
    step(10);
    chk_val("access_state", 16'(ST_DISPLAY), 16'(access_state));
    direct_setpoint_access = 1'b1;
    press('{1'b1, 1'b1, 1'b0, 1'b0});
    step(10);
    chk_val("access_state", 16'(ST_SELECT), 16'(access_state));
    step(TK * 20 + 30);
    chk_val("access_state", 16'(ST_DISPLAY), 16'(access_state));
    acode = 16'h0001;
    tap(B_COMBO);
    chk_val("access_state", 16'(ST_CODE), 16'(access_state));
    tap(B_EXIT);
    chk_val("access_state", 16'(ST_DISPLAY), 16'(access_state));
    tap(B_COMBO);
    tap(B_UP);
    tap(B_EXIT);
    chk_val("access_state", 16'(ST_SELECT), 16'(access_state));
    tap(B_NEXT);
    tap(B_NEXT);
    tap(B_UP);
    tap(B_EXIT);
    chk_val("first_setpoint", 16'h2332, first_setpoint);
    repeat (4) tap(B_NEXT);
    repeat (2) tap(B_UP);
    tap(B_EXIT);
    chk_val("first_setpoint", 16'h2332, first_setpoint);
    chk_val("access_state", 16'(ST_SELECT), 16'(access_state));
    tap(B_EXIT);
    chk_val("access_state", 16'(ST_DISPLAY), 16'(access_state));
    report_and_stop();
  end
endmodule : tb_dal_top
